// ---- hdl/mtp_timer.sv ----
// modulo interval timer sharing its match word and pins with the pwm
// assumes cpu flag writes, transfers and reset events come in on core_clk_i
`timescale 1ns/100ps

// Function
// - 8-bit counter counts selected basic clock
// - timer use forces three pins to port
// - timer use forces 8-bit converter length
// - rate flag bit 0 picks basic clock
// - select bit 3 enables other controls
// - enable bit 1 gates basic clock
// - writing clear bit 0 zeroes counter
// - interrupt request when count equals match
// - match word shares pwm word two storage
// - pwm words one, zero stay 9-bit latches
// - 16-bit transfer, upper bits read zero
// - hard, watchdog and clock-stop resets load all ones into words
// - enable does not resync basic clock
// - clear does not restart divider
// - chip-enable reset keeps state, disables interrupts while timer selected
module mtp_timer (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic wdt_rst_i,
	input wire logic clk_stop_i,
	input wire logic ce_rst_i,
	input wire logic int_enable_i,
	input wire logic ctl_wr_i,
	input wire logic [3:0] ctl_wdata_i,
	input wire logic cks_wr_i,
	input wire logic [3:0] cks_wdata_i,
	input wire logic put_i,
	input wire logic get_i,
	input wire logic [1:0] word_idx_i,
	input wire logic [15:0] xfer_wdata_i,
	output logic [15:0] xfer_rdata_o,
	output logic [3:0] ctl_rdata_o,
	output logic [3:0] cks_rdata_o,
	output logic [7:0] count_o,
	output logic irq_o,
	output logic int_disable_o,
	output logic [2:0] pins_gp_o,
	output logic len9_o
);
	// ****************************************
	// basic clocks
	// ****************************************
	logic fast_tick;
	logic slow_tick;

	// dividers run from reset on, so enable and clear never resync them
	mtp_rate_div #(.STEP(mtp_pkg::FAST_STEP), .MODULUS(mtp_pkg::ACC_MOD))
		u_fast (.core_clk_i(core_clk_i), .rst_i(rst_i), .tick_o(fast_tick));
	mtp_rate_div #(.STEP(mtp_pkg::SLOW_STEP), .MODULUS(mtp_pkg::ACC_MOD))
		u_slow (.core_clk_i(core_clk_i), .rst_i(rst_i), .tick_o(slow_tick));

	// ****************************************
	// control flags
	// ****************************************
	logic sel_q, sel_d;
	logic en_q, en_d;
	logic rate_q, rate_d;
	logic len9_q, len9_d;
	logic clr_req;
	logic soft_rst;

	assign soft_rst = wdt_rst_i | clk_stop_i;
	// clear only acts with the timer selected in the same write
	assign clr_req = ctl_wr_i & ctl_wdata_i[mtp_pkg::CTL_CLR_BIT] &
		ctl_wdata_i[mtp_pkg::CTL_SEL_BIT];

	always_comb begin
		sel_d = sel_q;
		en_d = en_q;
		rate_d = rate_q;
		len9_d = len9_q;
		if (soft_rst) begin
			sel_d = 1'b0;
			en_d = 1'b0;
			rate_d = 1'b0;
			len9_d = 1'b0;
		end else begin
			if (ctl_wr_i) begin
				sel_d = ctl_wdata_i[mtp_pkg::CTL_SEL_BIT];
				en_d = ctl_wdata_i[mtp_pkg::CTL_EN_BIT];
			end
			if (cks_wr_i) begin
				rate_d = cks_wdata_i[mtp_pkg::CKS_RATE_BIT];
				len9_d = cks_wdata_i[mtp_pkg::CKS_LEN9_BIT];
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_q <= 1'b0;
			en_q <= 1'b0;
			rate_q <= 1'b0;
			len9_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			en_q <= en_d;
			rate_q <= rate_d;
			len9_q <= len9_d;
		end
	end

	// ****************************************
	// shared word storage
	// ****************************************
	logic [mtp_pkg::WORD_W-1:0] word_q [mtp_pkg::N_WORDS];
	logic [mtp_pkg::WORD_W-1:0] word_d [mtp_pkg::N_WORDS];
	logic [mtp_pkg::WORD_W-1:0] match_w;

	// index two is both the match word and pwm word two
	assign match_w = word_q[mtp_pkg::IDX_MATCH];

	always_comb begin
		for (int i = 0; i < mtp_pkg::N_WORDS; i++) begin
			word_d[i] = word_q[i];
			if (soft_rst) begin
				word_d[i] = mtp_pkg::WORD_RST;
			end else if (put_i && word_idx_i == 2'(i)) begin
				// words one and zero latch all nine bits in any mode
				word_d[i] = xfer_wdata_i[mtp_pkg::WORD_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < mtp_pkg::N_WORDS; i++) begin
				word_q[i] <= mtp_pkg::WORD_RST;
			end
		end else begin
			for (int i = 0; i < mtp_pkg::N_WORDS; i++) begin
				word_q[i] <= word_d[i];
			end
		end
	end

	// ****************************************
	// counter and match
	// ****************************************
	logic [mtp_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic irq_q, irq_d;
	logic tick;
	logic step;
	logic at_match;

	assign tick = rate_q ? slow_tick : fast_tick;
	// enable only gates ticks; a tick may be missed at either edge
	assign step = tick & sel_q & en_q;
	// the 8-bit counter never reaches a match word above 0FFH
	assign at_match = ({1'b0, cnt_q} == match_w);

	always_comb begin
		cnt_d = cnt_q;
		irq_d = 1'b0;
		if (soft_rst || clr_req) begin
			cnt_d = mtp_pkg::CNT_RST;
		end else if (step) begin
			if (at_match) begin
				cnt_d = mtp_pkg::CNT_RST;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
			irq_d = ({1'b0, cnt_d} == match_w);
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= mtp_pkg::CNT_RST;
			irq_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			irq_q <= irq_d;
		end
	end

	// ****************************************
	// interrupt disable and pin outputs
	// ****************************************
	logic di_q, di_d;
	logic [2:0] gp_q, gp_d;
	logic len_out_q, len_out_d;

	always_comb begin
		di_d = di_q;
		if (int_enable_i || soft_rst) begin
			di_d = 1'b0;
		end
		// set wins over a clear in the same cycle
		if (ce_rst_i && sel_q) begin
			di_d = 1'b1;
		end
		gp_d = sel_q ? mtp_pkg::PINS_GP : 3'h0;
		len_out_d = len9_q & ~sel_q;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			di_q <= 1'b0;
			gp_q <= 3'h0;
			len_out_q <= 1'b0;
		end else begin
			di_q <= di_d;
			gp_q <= gp_d;
			len_out_q <= len_out_d;
		end
	end

	// ****************************************
	// read back
	// ****************************************
	logic [15:0] rdata_q, rdata_d;
	logic [3:0] ctl_rd_q, ctl_rd_d;
	logic [3:0] cks_rd_q, cks_rd_d;

	always_comb begin
		rdata_d = rdata_q;
		if (get_i && word_idx_i < 2'(mtp_pkg::N_WORDS)) begin
			rdata_d = {7'h00, word_q[word_idx_i]};
		end else if (get_i) begin
			rdata_d = 16'h0000;
		end
		// clear flag always reads zero
		ctl_rd_d = {sel_q, 1'b0, en_q, 1'b0};
		cks_rd_d = {2'h0, len9_q, rate_q};
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 16'h0000;
			ctl_rd_q <= 4'h0;
			cks_rd_q <= 4'h0;
		end else begin
			rdata_q <= rdata_d;
			ctl_rd_q <= ctl_rd_d;
			cks_rd_q <= cks_rd_d;
		end
	end

	assign xfer_rdata_o = rdata_q;
	assign ctl_rdata_o = ctl_rd_q;
	assign cks_rdata_o = cks_rd_q;
	assign count_o = cnt_q;
	assign irq_o = irq_q;
	assign int_disable_o = di_q;
	assign pins_gp_o = gp_q;
	assign len9_o = len_out_q;

	// ****************************************
	// checks
	// ****************************************
	property p_count_step;
		@(posedge core_clk_i) disable iff (rst_i)
		step && !at_match && !clr_req && !soft_rst
			|=> count_o == $past(count_o) + 8'h01;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not advance by one");

	property p_pins_gp;
		@(posedge core_clk_i) disable iff (rst_i)
		sel_q |=> pins_gp_o == 3'h7;
	endproperty
	a_pins_gp: assert property (p_pins_gp)
		else $error("pins not forced to port mode");

	property p_len8;
		@(posedge core_clk_i) disable iff (rst_i)
		sel_q |=> !len9_o;
	endproperty
	a_len8: assert property (p_len8)
		else $error("9-bit length while timer selected");

	property p_hold;
		@(posedge core_clk_i) disable iff (rst_i)
		!(sel_q && en_q) && !clr_req && !soft_rst |=> $stable(count_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("counter moved while stopped");

	property p_clear;
		@(posedge core_clk_i) disable iff (rst_i)
		clr_req |=> count_o == 8'h00 ##1 count_o <= 8'h01;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not zero counter");

	property p_irq_match;
		@(posedge core_clk_i) disable iff (rst_i)
		irq_o |-> {1'b0, count_o} == word_q[2];
	endproperty
	a_irq_match: assert property (p_irq_match)
		else $error("interrupt without match");

	property p_upper_zero;
		@(posedge core_clk_i) disable iff (rst_i)
		get_i |=> xfer_rdata_o[15:9] == 7'h00;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper transfer bits not zero");

	property p_soft_reset;
		@(posedge core_clk_i) disable iff (rst_i)
		wdt_rst_i || clk_stop_i |=> word_q[2] == 9'h1FF && !sel_q;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("match word not reloaded");

	property p_ce_di;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_rst_i && sel_q && !soft_rst && !ctl_wr_i
			|=> int_disable_o && $stable(sel_q) && $stable(en_q);
	endproperty
	a_ce_di: assert property (p_ce_di)
		else $error("chip-enable reset left interrupts on");

	property p_wrap;
		@(posedge core_clk_i) disable iff (rst_i)
		step && at_match && !soft_rst |=> count_o == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("counter not cleared after match");

	c_irq: cover property (@(posedge core_clk_i) disable iff (rst_i)
		irq_o ##[1:300] irq_o);
	c_clear: cover property (@(posedge core_clk_i) disable iff (rst_i)
		step ##1 clr_req);
	c_ce: cover property (@(posedge core_clk_i) disable iff (rst_i)
		ce_rst_i && sel_q && en_q);
endmodule

// ---- hdl/mtp_pkg.sv ----
// constants for the modulo interval timer that shares storage with the pwm
// assumes a single 25 MHz core clock and the cpu flag and transfer ports
package mtp_pkg;
	// ****************************************
	// clock and basic clock rates
	// ****************************************
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned FAST_HZ = 1_125_000;
	localparam int unsigned SLOW_HZ = 112_500;
	localparam int ACC_W = 25;
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
	localparam logic [ACC_W-1:0] FAST_STEP = ACC_W'(FAST_HZ);
	localparam logic [ACC_W-1:0] SLOW_STEP = ACC_W'(SLOW_HZ);
	// longest gap between two basic clock ticks, in core cycles
	localparam int FAST_GAP = (CLK_HZ + FAST_HZ - 1) / FAST_HZ;
	localparam int SLOW_GAP = (CLK_HZ + SLOW_HZ - 1) / SLOW_HZ;

	// ****************************************
	// flag positions
	// ****************************************
	localparam int CTL_SEL_BIT = 3;
	localparam int CTL_EN_BIT = 1;
	localparam int CTL_CLR_BIT = 0;
	localparam int CKS_RATE_BIT = 0;
	localparam int CKS_LEN9_BIT = 1;
	localparam int FLAG_W = 4;

	// ****************************************
	// storage and transfer
	// ****************************************
	localparam int CNT_W = 8;
	localparam int WORD_W = 9;
	localparam int XFER_W = 16;
	localparam int N_WORDS = 3;
	localparam logic [1:0] IDX_MATCH = 2'h2;
	localparam logic [WORD_W-1:0] WORD_RST = 9'h1FF;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic [2:0] PINS_GP = 3'h7;
endpackage

// ---- hdl/mtp_rate_div.sv ----
// fractional divider that turns the core clock into one basic clock tick
// assumes STEP below MODULUS; free running, never restarted by the timer
`timescale 1ns/100ps
module mtp_rate_div #(
	parameter logic [mtp_pkg::ACC_W-1:0] STEP = mtp_pkg::FAST_STEP,
	parameter logic [mtp_pkg::ACC_W-1:0] MODULUS = mtp_pkg::ACC_MOD
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	output logic tick_o
);
	logic [mtp_pkg::ACC_W-1:0] acc_q;
	logic [mtp_pkg::ACC_W-1:0] acc_d;
	logic [mtp_pkg::ACC_W:0] sum;
	logic tick_d;

	// phase accumulator keeps the average rate exact at non-integer ratios
	always_comb begin
		sum = {1'b0, acc_q} + {1'b0, STEP};
		tick_d = 1'b0;
		acc_d = sum[mtp_pkg::ACC_W-1:0];
		if (sum >= {1'b0, MODULUS}) begin
			acc_d = mtp_pkg::ACC_W'(sum - {1'b0, MODULUS});
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_q <= '0;
			tick_o <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick_o <= tick_d;
		end
	end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the modulo interval timer, one task per scenario
// assumes mtp_timer is compiled; the bench drives every strobe itself
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end

module tb_top;
	// ****************************************
	// stimulus and wiring
	// ****************************************
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wdt_rst_i = 1'b0, clk_stop_i = 1'b0, ce_rst_i = 1'b0;
	logic int_enable_i = 1'b0, ctl_wr_i = 1'b0, cks_wr_i = 1'b0;
	logic [3:0] ctl_wdata_i = 4'h0, cks_wdata_i = 4'h0;
	logic put_i = 1'b0, get_i = 1'b0;
	logic [1:0] word_idx_i = 2'h0;
	logic [15:0] xfer_wdata_i = 16'h0000, xfer_rdata_o;
	logic [3:0] ctl_rdata_o, cks_rdata_o;
	logic [7:0] count_o;
	logic irq_o, int_disable_o, len9_o;
	logic [2:0] pins_gp_o;
	int err_count = 0;
	int checked = 0;

	always #20 core_clk_i = ~core_clk_i;

	mtp_timer dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.wdt_rst_i(wdt_rst_i), .clk_stop_i(clk_stop_i), .ce_rst_i(ce_rst_i),
		.int_enable_i(int_enable_i), .ctl_wr_i(ctl_wr_i),
		.ctl_wdata_i(ctl_wdata_i), .cks_wr_i(cks_wr_i),
		.cks_wdata_i(cks_wdata_i), .put_i(put_i), .get_i(get_i),
		.word_idx_i(word_idx_i), .xfer_wdata_i(xfer_wdata_i),
		.xfer_rdata_o(xfer_rdata_o), .ctl_rdata_o(ctl_rdata_o),
		.cks_rdata_o(cks_rdata_o), .count_o(count_o), .irq_o(irq_o),
		.int_disable_o(int_disable_o), .pins_gp_o(pins_gp_o),
		.len9_o(len9_o));

	// ****************************************
	// drivers
	// ****************************************
	task tk(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task ctl(input logic [3:0] v);
		@(posedge core_clk_i);
		ctl_wr_i <= 1'b1;
		ctl_wdata_i <= v;
		@(posedge core_clk_i);
		ctl_wr_i <= 1'b0;
		tk(2);
	endtask
	task cks(input logic [3:0] v);
		@(posedge core_clk_i);
		cks_wr_i <= 1'b1;
		cks_wdata_i <= v;
		@(posedge core_clk_i);
		cks_wr_i <= 1'b0;
		tk(2);
	endtask
	// 0 watchdog, 1 chip-enable, 2 interrupt enable, 3 clock stop
	task ev(input int k);
		@(posedge core_clk_i);
		case (k)
			0: wdt_rst_i <= 1'b1;
			1: ce_rst_i <= 1'b1;
			2: int_enable_i <= 1'b1;
			default: clk_stop_i <= 1'b1;
		endcase
		@(posedge core_clk_i);
		{wdt_rst_i, ce_rst_i, int_enable_i, clk_stop_i} <= 4'h0;
		tk(2);
	endtask
	task put(input logic [1:0] i, input logic [15:0] v);
		@(posedge core_clk_i);
		put_i <= 1'b1;
		word_idx_i <= i;
		xfer_wdata_i <= v;
		@(posedge core_clk_i);
		put_i <= 1'b0;
		tk(1);
	endtask
	task get(input logic [1:0] i, output logic [15:0] d);
		@(posedge core_clk_i);
		get_i <= 1'b1;
		word_idx_i <= i;
		@(posedge core_clk_i);
		get_i <= 1'b0;
		tk(1);
		d = xfer_rdata_o;
	endtask
	// bounded waits; the bound keeps a dead divider from hanging the run
	task wait_irq(output int n);
		n = 0;
		while (irq_o !== 1'b1 && n < 600) begin
			tk(1);
			n++;
		end
		if (n >= 600)
			err_count++;
	endtask
	task wait_chg(output int n);
		logic [7:0] c;
		c = count_o;
		n = 0;
		while (count_o === c && n < 600) begin
			tk(1);
			n++;
		end
		if (n >= 600)
			err_count++;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		logic [15:0] d;
		for (int i = 0; i < 3; i++) begin
			get(2'(i), d);
			`CHK(d, 16'h01FF)
		end
		`CHK(count_o, 8'h00)
		`CHK(ctl_rdata_o, 4'h0)
	endtask
	task t_xfer;
		logic [15:0] d;
		put(2'h2, 16'hFE05);
		get(2'h2, d);
		`CHK(d, 16'h0005)
		put(2'h0, 16'h01AB);
		get(2'h0, d);
		`CHK(d, 16'h01AB)
		get(2'h1, d);
		`CHK(d, 16'h01FF)
		put(2'h3, 16'h0077);
		get(2'h3, d);
		`CHK(d, 16'h0000)
	endtask
	task t_sel;
		cks(4'h2);
		`CHK(len9_o, 1'b1)
		`CHK(pins_gp_o, 3'h0)
		ctl(4'h8);
		`CHK(len9_o, 1'b0)
		`CHK(pins_gp_o, 3'h7)
		`CHK(ctl_rdata_o, 4'h8)
		`CHK(cks_rdata_o, 4'h2)
	endtask
	task t_run;
		int n, w;
		put(2'h2, 16'h0003);
		cks(4'h0);
		ctl(4'hB);
		wait_irq(n);
		`CHK(irq_o, 1'b1)
		`CHK(count_o, 8'h03)
		tk(1);
		`CHK(irq_o, 1'b0)
		wait_chg(w);
		`CHK(count_o, 8'h00)
		wait_irq(n);
		`CHK(irq_o, 1'b1)
		// four fast ticks of 22 or 23 core cycles each
		`CHK((w + n >= 86 && w + n <= 94), 1'b1)
	endtask
	task t_slow;
		int n;
		cks(4'h1);
		wait_chg(n);
		wait_chg(n);
		`CHK((n >= 221 && n <= 224), 1'b1)
		cks(4'h0);
	endtask
	task t_stop;
		int n;
		logic [7:0] c;
		ctl(4'h8);
		c = count_o;
		tk(300);
		`CHK(count_o, c)
		// restart from zero so the stop lands well clear of a tick
		ctl(4'hB);
		n = 0;
		while (count_o !== 8'h01 && n < 100) begin
			tk(1);
			n++;
		end
		ctl(4'h3);
		c = count_o;
		`CHK(c, 8'h01)
		tk(60);
		`CHK(count_o, c)
		ctl(4'h9);
		`CHK(count_o, 8'h00)
	endtask
	task t_ce;
		int n;
		ctl(4'hA);
		ev(1);
		`CHK(int_disable_o, 1'b1)
		wait_chg(n);
		`CHK((n < 30), 1'b1)
		ev(2);
		`CHK(int_disable_o, 1'b0)
	endtask
	task t_wdt;
		logic [15:0] d;
		put(2'h0, 16'h0012);
		ev(0);
		get(2'h0, d);
		`CHK(d, 16'h01FF)
		`CHK(count_o, 8'h00)
		`CHK(pins_gp_o, 3'h0)
		put(2'h1, 16'h0055);
		ev(3);
		get(2'h1, d);
		`CHK(d, 16'h01FF)
	endtask

	// ****************************************
	// sequence and verdict
	// ****************************************
	task wrap_up;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		tk(1);
		t_reset();
		t_xfer();
		t_sel();
		t_run();
		t_slow();
		t_stop();
		t_ce();
		t_wdt();
		wrap_up();
	end

	// whole run is about a thousand cycles; this margin only catches a hang
	initial begin
		repeat (40000) @(posedge core_clk_i);
		err_count++;
		wrap_up();
	end
endmodule
